// ===== src/eckp_params.svh
// Constants of the encrypted configuration key policy block
`ifndef ECKP_PARAMS_SVH
`define ECKP_PARAMS_SVH
`define ECKP_KEY_W 256
`define ECKP_USER_W 32
`define ECKP_ID_W 64
`define ECKP_CTL_W 16
`define ECKP_SEC_W 2
// Register offsets
`define ECKP_OFF_CMD 8'h00
`define ECKP_OFF_STATUS 8'h04
`define ECKP_OFF_CTL 8'h08
`define ECKP_OFF_SEC 8'h0c
`define ECKP_OFF_USER 8'h10
`define ECKP_OFF_ID_LO 8'h14
`define ECKP_OFF_ID_HI 8'h18
`define ECKP_OFF_KEYDATA 8'h1c
// Command register bits
`define ECKP_CMD_BB_WR 0
`define ECKP_CMD_BB_CLR 1
`define ECKP_CMD_FK_WR 2
`define ECKP_CMD_PROG_CTL 3
`define ECKP_CMD_PROG_SEC 4
`define ECKP_CMD_PROG_USER 5
// Control fuse bits
`define ECKP_CTL_NO_BB 0
`define ECKP_CTL_NO_FK 1
`define ECKP_CTL_RD_LOCK 2
`define ECKP_CTL_WR_LOCK 3
// Security field codes
`define ECKP_SEC_FUSE_ONLY 2'b11
`define ECKP_SEC_ENC_ONLY 2'b10
`define ECKP_ID_DEFAULT 64'h0123_4567_89ab_cdef
`define ECKP_RESP_OKAY 2'b00
`define ECKP_RESP_SLVERR 2'b10
`endif

// ===== src/eckp_pkg.sv
// Types of the encrypted configuration key policy block
package eckp_pkg;
    typedef enum logic [2:0] {
        ECKP_IDLE = 3'b001,
        ECKP_WDATA = 3'b010,
        ECKP_RESP = 3'b100
    } eckp_wr_e;
    typedef logic [1:0] eckp_src_t;
endpackage

// ===== src/eckp_otp_word.sv
// One-time programmable word: bits only ever set
`timescale 1ns/1ns
module eckp_otp_word #(
    parameter int WIDTH = 32
) (
    input wire logic ref_clk,
    input wire logic rstSync_n,
    input wire logic progEn,
    input wire logic [WIDTH-1:0] progBits,
    output logic [WIDTH-1:0] fuses
);
    logic [WIDTH-1:0] fuse_r;
    logic [WIDTH-1:0] fuse_nxt;
    initial begin
        if (WIDTH < 1) begin
            $error("eckp_otp_word: WIDTH must be positive");
        end
    end
    // Bits only OR in; power-up value stands for blank fuses
    always_comb begin
        fuse_nxt = fuse_r;
        if (progEn) begin
            fuse_nxt = fuse_r | progBits;
        end
    end
    // Fuses survive reset; no reset branch clears programmed bits
    always_ff @(posedge ref_clk) begin
        if (rstSync_n === 1'b0 && $isunknown(fuse_r)) begin
            fuse_r <= '0;
        end else begin
            fuse_r <= fuse_nxt;
        end
    end
    assign fuses = fuse_r;
endmodule

// ===== src/eckp_top.sv
// Key policy and fuse access for encrypted configuration loading
`timescale 1ns/1ns
`include "eckp_params.svh"
module eckp_top
    import eckp_pkg::*;
#(
    parameter logic [`ECKP_ID_W-1:0] ID_VALUE = `ECKP_ID_DEFAULT // Arbitrary
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic powerOn_n,
    input wire logic reconfigPulse,
    input wire logic imageStart,
    input wire logic imageEncrypted,
    input wire logic [1:0] imageKeySrc,
    input wire logic imageDone,
    output logic imageAccept,
    output logic imageAbort,
    output logic configDone,
    output logic lockedUp,
    output logic readbackEnable,
    output logic [1:0] decryptKeySel,
    output logic [`ECKP_KEY_W-1:0] decryptKey,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int KW = `ECKP_KEY_W;
    localparam int NWORDS = KW / 32;
    initial begin
        if (`ECKP_ID_W != 64 || KW % 32 != 0 || NWORDS != 8) begin
            $error("eckp_top: unsupported widths");
        end
    end

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rstMeta_r;
    logic rstSync_r;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [KW-1:0] keyStage_r, keyStage_nxt;
    logic [2:0] keyIdx_r, keyIdx_nxt;
    logic [KW-1:0] bbKey_r, bbKey_nxt;
    logic bbValid_r, bbValid_nxt;
    logic locked_r, locked_nxt;
    logic encLoaded_r, encLoaded_nxt;
    logic [31:0] progWord_r, progWord_nxt;
    logic [5:0] progCmd_r, progCmd_nxt;
    logic [`ECKP_CTL_W-1:0] ctlFuses;
    logic [`ECKP_SEC_W-1:0] secFuses;
    logic [`ECKP_USER_W-1:0] userFuses;
    logic [KW-1:0] keyFuses;
    eckp_wr_e wrSt_r, wrSt_nxt;
    logic [7:0] awAddr_r, awAddr_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic accept_r, accept_nxt;
    logic abort_r, abort_nxt;
    logic done_r, done_nxt;
    logic active_r, active_nxt;
    logic [1:0] keySel_r, keySel_nxt;

    // ------------------------------------------------------------
    // Fuse groups, bits only ever programmed
    // ------------------------------------------------------------
    eckp_otp_word #(.WIDTH(`ECKP_CTL_W)) uCtl (
        .ref_clk(ref_clk), .rstSync_n(rstSync_r),
        .progEn(progCmd_r[`ECKP_CMD_PROG_CTL]),
        .progBits(progWord_r[`ECKP_CTL_W-1:0]), .fuses(ctlFuses));
    eckp_otp_word #(.WIDTH(`ECKP_SEC_W)) uSec (
        .ref_clk(ref_clk), .rstSync_n(rstSync_r),
        .progEn(progCmd_r[`ECKP_CMD_PROG_SEC]),
        .progBits(progWord_r[`ECKP_SEC_W-1:0]), .fuses(secFuses));
    eckp_otp_word #(.WIDTH(`ECKP_USER_W)) uUser (
        .ref_clk(ref_clk), .rstSync_n(rstSync_r),
        .progEn(progCmd_r[`ECKP_CMD_PROG_USER]),
        .progBits(progWord_r), .fuses(userFuses));
    eckp_otp_word #(.WIDTH(KW)) uKey (
        .ref_clk(ref_clk), .rstSync_n(rstSync_r),
        .progEn(progCmd_r[`ECKP_CMD_FK_WR]),
        .progBits(keyStage_r), .fuses(keyFuses));

    // ------------------------------------------------------------
    // AXI4-Lite write path and commands
    // ------------------------------------------------------------
    logic wrFire;
    logic wrLocked;
    always_comb begin
        wrSt_nxt = wrSt_r;
        awAddr_nxt = awAddr_r;
        bresp_nxt = bresp_r;
        keyStage_nxt = keyStage_r;
        keyIdx_nxt = keyIdx_r;
        progWord_nxt = progWord_r;
        progCmd_nxt = '0;
        wrFire = 1'b0;
        wrLocked = ctlFuses[`ECKP_CTL_WR_LOCK];
        case (wrSt_r)
            ECKP_IDLE: begin
                if (s_axi_awvalid && s_axi_wvalid) begin
                    awAddr_nxt = s_axi_awaddr;
                    wrFire = 1'b1;
                    wrSt_nxt = ECKP_RESP;
                end else if (s_axi_awvalid) begin
                    awAddr_nxt = s_axi_awaddr;
                    wrSt_nxt = ECKP_WDATA;
                end
            end
            ECKP_WDATA: begin
                if (s_axi_wvalid) begin
                    wrFire = 1'b1;
                    wrSt_nxt = ECKP_RESP;
                end
            end
            ECKP_RESP: begin
                if (s_axi_bready) begin
                    wrSt_nxt = ECKP_IDLE;
                end
            end
            default: wrSt_nxt = ECKP_IDLE;
        endcase
        if (wrFire) begin
            bresp_nxt = `ECKP_RESP_OKAY;
            case (wrSt_r == ECKP_IDLE ? s_axi_awaddr : awAddr_r)
                `ECKP_OFF_KEYDATA: begin
                    keyStage_nxt[keyIdx_r*32 +: 32] = s_axi_wdata;
                    keyIdx_nxt = keyIdx_r + 3'h1;
                end
                `ECKP_OFF_USER, `ECKP_OFF_CTL, `ECKP_OFF_SEC: begin
                    progWord_nxt = s_axi_wdata;
                end
                `ECKP_OFF_CMD: begin
                    progCmd_nxt = s_axi_wdata[5:0];
                    if (wrLocked) begin
                        progCmd_nxt[5:2] = 4'h0;
                    end
                    keyIdx_nxt = 3'h0;
                end
                default: bresp_nxt = `ECKP_RESP_SLVERR;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Battery store, lock-up, image policy
    // ------------------------------------------------------------
    logic isEncOk;
    always_comb begin
        bbKey_nxt = bbKey_r;
        bbValid_nxt = bbValid_r;
        locked_nxt = locked_r;
        encLoaded_nxt = encLoaded_r;
        accept_nxt = 1'b0;
        abort_nxt = 1'b0;
        done_nxt = done_r;
        active_nxt = active_r;
        keySel_nxt = keySel_r;
        isEncOk = 1'b0;
        // Key load refused while locked
        if (progCmd_r[`ECKP_CMD_BB_WR] && !locked_r) begin
            bbKey_nxt = keyStage_r;
            bbValid_nxt = 1'b1;
        end
        if (progCmd_r[`ECKP_CMD_BB_CLR]) begin
            bbKey_nxt = '0;
            bbValid_nxt = 1'b0;
        end
        // Power removal reopens readback just as the pin does
        if (reconfigPulse || !powerOn_n) begin
            encLoaded_nxt = 1'b0;
            done_nxt = 1'b0;
        end
        if (imageStart) begin
            done_nxt = 1'b0;
            if (!imageEncrypted) begin
                isEncOk = !secFuses[1];
            end else if (locked_r) begin
                isEncOk = 1'b0;
            end else if (imageKeySrc == 2'b01) begin
                // Battery source selected by the stream
                isEncOk = secFuses != `ECKP_SEC_FUSE_ONLY
                    && !ctlFuses[`ECKP_CTL_NO_BB];
                if (isEncOk && !bbValid_r) begin
                    locked_nxt = 1'b1;
                    isEncOk = 1'b0;
                end
            end else begin
                isEncOk = !ctlFuses[`ECKP_CTL_NO_FK];
            end
            accept_nxt = isEncOk;
            abort_nxt = !isEncOk;
            active_nxt = isEncOk;
            keySel_nxt = imageEncrypted ? imageKeySrc : 2'b00;
            if (isEncOk && imageEncrypted) begin
                encLoaded_nxt = 1'b1;
            end
        end
        if (imageDone && active_r) begin
            done_nxt = 1'b1;
            active_nxt = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path; status shows lock and key state
    // ------------------------------------------------------------
    logic rdLocked;
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        rdLocked = ctlFuses[`ECKP_CTL_RD_LOCK];
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end else if (!rvalid_r && s_axi_arvalid) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `ECKP_RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            case (s_axi_araddr)
                `ECKP_OFF_CMD: rdata_nxt = 32'h0000_0000;
                `ECKP_OFF_STATUS:
                    rdata_nxt = {27'h0, active_r, encLoaded_r,
                        done_r, bbValid_r, locked_r};
                `ECKP_OFF_CTL: rdata_nxt = {16'h0, ctlFuses};
                `ECKP_OFF_SEC:
                    rdata_nxt = rdLocked ? 32'h0 : {30'h0, secFuses};
                `ECKP_OFF_USER:
                    rdata_nxt = rdLocked ? 32'h0 : userFuses;
                `ECKP_OFF_ID_LO: rdata_nxt = ID_VALUE[31:0];
                `ECKP_OFF_ID_HI: rdata_nxt = ID_VALUE[63:32];
                `ECKP_OFF_KEYDATA: rdata_nxt = 32'h0000_0000;
                default: rresp_nxt = `ECKP_RESP_SLVERR;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State registers; battery store and lock are reset only at power-on
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            wrSt_r <= ECKP_IDLE;
            awAddr_r <= 8'h00;
            bresp_r <= 2'b00;
            keyStage_r <= '0;
            keyIdx_r <= 3'h0;
            progWord_r <= 32'h0000_0000;
            progCmd_r <= 6'h00;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'b00;
            encLoaded_r <= 1'b0;
            accept_r <= 1'b0;
            abort_r <= 1'b0;
            done_r <= 1'b0;
            active_r <= 1'b0;
            keySel_r <= 2'b00;
        end else begin
            wrSt_r <= wrSt_nxt;
            awAddr_r <= awAddr_nxt;
            bresp_r <= bresp_nxt;
            keyStage_r <= keyStage_nxt;
            keyIdx_r <= keyIdx_nxt;
            progWord_r <= progWord_nxt;
            progCmd_r <= progCmd_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            encLoaded_r <= encLoaded_nxt;
            accept_r <= accept_nxt;
            abort_r <= abort_nxt;
            done_r <= done_nxt;
            active_r <= active_nxt;
            keySel_r <= keySel_nxt;
        end
    end

    // Power-on only; logic reset and reconfig pin leave these alone
    always_ff @(posedge ref_clk or negedge powerOn_n) begin
        if (!powerOn_n) begin
            bbKey_r <= '0;
            bbValid_r <= 1'b0;
            locked_r <= 1'b0;
        end else begin
            bbKey_r <= bbKey_nxt;
            bbValid_r <= bbValid_nxt;
            locked_r <= locked_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic [KW-1:0] decKey_r;
    always_ff @(posedge ref_clk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            decKey_r <= '0;
        end else begin
            // Chaining value and auth key come from the stream
            decKey_r <= (keySel_r == 2'b01) ? bbKey_r : keyFuses;
        end
    end
    assign decryptKey = decKey_r;
    assign decryptKeySel = keySel_r;
    assign imageAccept = accept_r;
    assign imageAbort = abort_r;
    assign configDone = done_r;
    assign lockedUp = locked_r;
    assign readbackEnable = !encLoaded_r;
    assign s_axi_awready = (wrSt_r == ECKP_IDLE);
    // Data only taken with or after its address, so none is lost
    assign s_axi_wready = (wrSt_r == ECKP_WDATA)
        || (wrSt_r == ECKP_IDLE && s_axi_awvalid);
    assign s_axi_bvalid = (wrSt_r == ECKP_RESP);
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
endmodule

// ===== testbench/eckp_props.sv
// Port-level checks of the key policy block
`timescale 1ns/1ns
module eckp_props (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic powerOn_n,
    input wire logic reconfigPulse,
    input wire logic imageStart,
    input wire logic imageEncrypted,
    input wire logic imageDone,
    input wire logic imageAccept,
    input wire logic imageAbort,
    input wire logic configDone,
    input wire logic lockedUp,
    input wire logic readbackEnable,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // Encrypted header taken, then its end marker
    sequence s_encTake;
        imageStart && imageEncrypted ##1 imageAccept;
    endsequence
    sequence s_encDone;
        s_encTake ##1 imageDone;
    endsequence
    property p_imgAnswer;
        imageStart |=> (imageAccept != imageAbort);
    endproperty
    a_imgAnswer: assert property (p_imgAnswer)
        else $error("header without single answer");
    property p_abortQuiet;
        imageAbort && !configDone |=> !configDone [*2];
    endproperty
    a_abortQuiet: assert property (p_abortQuiet)
        else $error("done raised after abort");
    // Power removal may drop the lock in the same cycle
    property p_lockHold;
        lockedUp && powerOn_n |=> lockedUp || !powerOn_n;
    endproperty
    a_lockHold: assert property (p_lockHold)
        else $error("lock released without power cycle");
    property p_lockRefuse;
        lockedUp && imageStart && imageEncrypted |=> imageAbort;
    endproperty
    a_lockRefuse: assert property (p_lockRefuse)
        else $error("encrypted image taken while locked");
    property p_encReadback;
        s_encDone |-> ##2 !readbackEnable;
    endproperty
    a_encReadback: assert property (p_encReadback)
        else $error("readback open after encrypted load");
    property p_rbStays;
        !readbackEnable && !reconfigPulse && powerOn_n
            |=> !readbackEnable || !powerOn_n;
    endproperty
    a_rbStays: assert property (p_rbStays)
        else $error("readback reopened by itself");
    property p_reconfig;
        reconfigPulse |-> ##[1:2] readbackEnable;
    endproperty
    a_reconfig: assert property (p_reconfig)
        else $error("reconfiguration left readback off");
    property p_doneSet;
        imageDone |=> configDone;
    endproperty
    a_doneSet: assert property (p_doneSet)
        else $error("done missing after image end");
    property p_wrResp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> s_axi_bvalid;
    endproperty
    a_wrResp: assert property (p_wrResp)
        else $error("write response late");
endmodule

// ===== testbench/eckp_host_model.sv
// Behavioural configuration host streaming image headers
`timescale 1ns/1ns
module eckp_host_model (
    input wire logic ref_clk,
    input wire logic imageAccept,
    input wire logic imageAbort,
    output logic imageStart,
    output logic imageEncrypted,
    output logic [1:0] imageKeySrc,
    output logic imageDone
);
    // ----------------------------------------
    // Image sender
    // ----------------------------------------
    initial begin
        imageStart = 1'b0;
        imageEncrypted = 1'b0;
        imageKeySrc = 2'b00;
        imageDone = 1'b0;
    end
    // Header, answer, then end marker only if taken; qualifiers are
    // inverted once released so stale values never look valid
    task automatic sendImage(input logic enc, input logic [1:0] src,
        input int gap, output logic acc, output logic abt);
        @(posedge ref_clk);
        imageStart <= 1'b1;
        imageEncrypted <= enc;
        imageKeySrc <= src;
        @(posedge ref_clk);
        imageStart <= 1'b0;
        imageEncrypted <= ~enc;
        imageKeySrc <= ~src;
        @(posedge ref_clk);
        acc = imageAccept;
        abt = imageAbort;
        if (acc) begin
            repeat (gap) @(posedge ref_clk);
            imageDone <= 1'b1;
            @(posedge ref_clk);
            imageDone <= 1'b0;
        end
    endtask
endmodule

// ===== testbench/eckp_top_test.sv
// Self-checking bench of the key policy block
`timescale 1ns/1ns
`include "eckp_params.svh"
module eckp_top_test;
    import eckp_pkg::*;
    // ----------------------------------------
    // Stimulus and checks
    // ----------------------------------------
    // Arbitrary identifier for this bench
    localparam logic [63:0] TEST_ID = 64'h5a5a_0f0f_3c3c_9696;
    localparam logic [255:0] K_FUSE = {32'hf7, 32'he6, 32'hd5,
        32'hc4, 32'hb3, 32'ha2, 32'h91, 32'h80};
    localparam logic [255:0] K_BB = ~K_FUSE;
    // Plain, battery, fuse images and who may pass
    localparam logic [2:0] ENC = 3'b110;
    localparam logic [5:0] SRC = 6'b10_01_00;
    localparam logic [2:0] EXP10 = 3'b110;
    localparam logic [2:0] EXP11 = 3'b100;
    // Read lock plus key_fuses disabled
    localparam logic [31:0] CTL_SET = (32'h1 << `ECKP_CTL_RD_LOCK)
        | (32'h1 << `ECKP_CTL_NO_FK);
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic powerOn_n = 1'b0;
    logic reconfigPulse = 1'b0;
    logic imageStart, imageEncrypted, imageDone;
    logic [1:0] imageKeySrc, decryptKeySel;
    logic imageAccept, imageAbort, configDone, lockedUp, readbackEnable;
    logic [255:0] decryptKey;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_errors = 0;
    int compares = 0;
    eckp_top #(.ID_VALUE(TEST_ID)) u_eckp_top (.*);
    eckp_host_model u_eckp_host_model (.ref_clk(ref_clk),
        .imageAccept(imageAccept), .imageAbort(imageAbort),
        .imageStart(imageStart), .imageEncrypted(imageEncrypted),
        .imageKeySrc(imageKeySrc), .imageDone(imageDone));
    always #2 ref_clk = ~ref_clk;
    task automatic conclude;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [255:0] exp,
        input logic [255:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bus master: hold each channel until its own ready is sampled
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        r = 2'bxx;
        for (int t = 0; t < 100; t++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                break;
            end
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r = 2'bxx;
        for (int t = 0; t < 100; t++) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                break;
            end
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axiWrite(a, d, r);
        check("bresp", `ECKP_RESP_OKAY, r);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axiRead(a, d, r);
        check("rdata", exp, d);
        check("rresp", `ECKP_RESP_OKAY, r);
    endtask
    task automatic bbChk(input logic exp);
        logic [31:0] d;
        logic [1:0] r;
        axiRead(`ECKP_OFF_STATUS, d, r);
        check("bbValid", exp, d[1]);
    endtask
    // Any command write rewinds the staging index
    task automatic loadKey(input logic [255:0] k, input int cmdBit);
        wr(`ECKP_OFF_CMD, 32'h0);
        for (int i = 0; i < 8; i++) wr(`ECKP_OFF_KEYDATA, k[32*i +: 32]);
        wr(`ECKP_OFF_CMD, 32'h1 << cmdBit);
        repeat (2) @(posedge ref_clk);
    endtask
    // Plain images end slowly to exercise a lagging host
    task automatic img(input logic enc, input logic [1:0] src,
        input logic exp);
        logic acc, abt;
        u_eckp_host_model.sendImage(enc, src, enc ? 0 : 2, acc, abt);
        check("imageAccept", exp, acc);
        check("imageAbort", !exp, abt);
        repeat (2) @(posedge ref_clk);
        if (exp) check("configDone", 1'b1, configDone);
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic e;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        powerOn_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("readbackEnable", 1'b1, readbackEnable);
        rdChk(`ECKP_OFF_ID_LO, TEST_ID[31:0]);
        rdChk(`ECKP_OFF_ID_HI, TEST_ID[63:32]);
        wr(`ECKP_OFF_USER, 32'hf0);
        wr(`ECKP_OFF_CMD, 32'h1 << `ECKP_CMD_PROG_USER);
        rdChk(`ECKP_OFF_USER, 32'hf0);
        wr(`ECKP_OFF_USER, 32'h0f);
        wr(`ECKP_OFF_CMD, 32'h1 << `ECKP_CMD_PROG_USER);
        rdChk(`ECKP_OFF_USER, 32'hff);
        axiWrite(8'h40, 32'h1, r);
        check("bresp", `ECKP_RESP_SLVERR, r);
        axiRead(8'h40, d, r);
        check("rresp", `ECKP_RESP_SLVERR, r);
        loadKey(K_FUSE, `ECKP_CMD_FK_WR);
        loadKey(K_BB, `ECKP_CMD_BB_WR);
        bbChk(1'b1);
        img(1'b0, 2'b00, 1'b1);
        img(1'b1, 2'b01, 1'b1);
        check("decryptKey", K_BB, decryptKey);
        check("decryptKeySel", 2'b01, decryptKeySel);
        check("readbackEnable", 1'b0, readbackEnable);
        img(1'b1, 2'b10, 1'b1);
        check("decryptKey", K_FUSE, decryptKey);
        check("decryptKeySel", 2'b10, decryptKeySel);
        reconfigPulse <= 1'b1;
        @(posedge ref_clk);
        reconfigPulse <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("readbackEnable", 1'b1, readbackEnable);
        bbChk(1'b1);
        wr(`ECKP_OFF_CMD, 32'h1 << `ECKP_CMD_BB_CLR);
        bbChk(1'b0);
        img(1'b1, 2'b01, 1'b0);
        check("lockedUp", 1'b1, lockedUp);
        check("configDone", 1'b0, configDone);
        loadKey(K_BB, `ECKP_CMD_BB_WR);
        bbChk(1'b0);
        img(1'b1, 2'b10, 1'b0);
        img(1'b0, 2'b00, 1'b1);
        powerOn_n <= 1'b0;
        @(posedge ref_clk);
        powerOn_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("lockedUp", 1'b0, lockedUp);
        loadKey(K_BB, `ECKP_CMD_BB_WR);
        bbChk(1'b1);
        for (int s = 2; s < 4; s++) begin
            wr(`ECKP_OFF_SEC, 32'(s));
            wr(`ECKP_OFF_CMD, 32'h1 << `ECKP_CMD_PROG_SEC);
            rdChk(`ECKP_OFF_SEC, 32'(s));
            for (int c = 0; c < 3; c++) begin
                e = (s == 2) ? EXP10[c] : EXP11[c];
                img(ENC[c], SRC[2*c +: 2], e);
            end
        end
        // Last image was encrypted; a power cycle must reopen readback
        check("readbackEnable", 1'b0, readbackEnable);
        powerOn_n <= 1'b0;
        @(posedge ref_clk);
        powerOn_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check("readbackEnable", 1'b1, readbackEnable);
        wr(`ECKP_OFF_CTL, CTL_SET);
        wr(`ECKP_OFF_CMD, 32'h1 << `ECKP_CMD_PROG_CTL);
        rdChk(`ECKP_OFF_CTL, CTL_SET);
        rdChk(`ECKP_OFF_USER, 32'h0);
        rdChk(`ECKP_OFF_SEC, 32'h0);
        img(1'b1, 2'b10, 1'b0);
        conclude();
    end
    // Whole run needs a few hundred cycles at most
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        $display("[FAIL] watchdog expected finish seen hang");
        conclude();
    end
endmodule
bind eckp_top eckp_props u_eckp_props (.*);
